// *** rtl/ics_cfg.svh ***
`ifndef ICS_CFG_SVH
`define ICS_CFG_SVH

// Register byte offsets
`define ICS_OFF_CTRL 8'h00
`define ICS_OFF_STATUS 8'h04
`define ICS_OFF_DATA 8'h08
`define ICS_OFF_ADDR 8'h0c
`define ICS_OFF_IRQ_STAT 8'h10
`define ICS_OFF_IRQ_EN 8'h14
`define ICS_OFF_IRQ_CLR 8'h18

// Control register fields
`define ICS_CTRL_RXEN_BIT 0
`define ICS_CTRL_TENBIT_BIT 1
`define ICS_CTRL_RELEASE_BIT 2

// Reset values
`define ICS_CTRL_RST 2'h0
`define ICS_RELEASE_RST 1'b1
`define ICS_ADDR_RST 10'h000
`define ICS_IRQ_RST 3'h0

// Bus framing
`define ICS_BIT_LAST 4'h8
`define ICS_BIT_ACK 4'h9
`define ICS_TENBIT_PREFIX 5'h1e

`endif

// *** rtl/ics_pkg.sv ***
package ics_pkg;

    typedef enum logic [2:0] {
        ICS_IDLE = 3'b000,
        ICS_ADDR1 = 3'b001,
        ICS_ADDR2 = 3'b010,
        ICS_RXDATA = 3'b011,
        ICS_TXDATA = 3'b100
    } ics_phase_t;

    typedef struct packed {
        logic tenBit;
        logic rxStretchEn;
    } ics_ctrl_t;

    typedef struct packed {
        logic overflow;
        logic stretch;
        logic byteDone;
    } ics_irq_t;

endpackage

// *** rtl/ics_clock_stretch.sv ***
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ics_cfg.svh"

module ics_clock_stretch #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Interrupt
    output logic irq
);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic sclS1_ff, sclS2_ff, sclPrev_ff, sdaS1_ff, sdaS2_ff, sdaPrev_ff;
    logic pready_ff, pslverr_ff, irq_ff, sclOe_ff, sdaOe_ff, sclOut_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rdVal;
    logic mapped;
    ics_pkg::ics_ctrl_t ctrl_ff;
    ics_pkg::ics_irq_t irqStat_ff, irqEn_ff, irqEv;
    logic clockRelease_ff, addrHold_ff, ua_ff, full_ff, txWait_ff;
    logic [9:0] slaveAddr_ff;
    logic [7:0] dataBuf_ff, rxShift_ff, txShift_ff;
    logic [3:0] bitCnt_ff;
    ics_pkg::ics_phase_t phase_ff, pendPhase_ff, nxtPhase;
    logic hiMatched_ff, nxtHi, ackNow, uaNow, uaPend_ff, masterNack_ff;

    // Pin synchronisers and edge/condition detect
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclS1_ff <= 1'b1;
            sclS2_ff <= 1'b1;
            sclPrev_ff <= 1'b1;
            sdaS1_ff <= 1'b1;
            sdaS2_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end
        else
        begin
            sclS1_ff <= sclIn;
            sclS2_ff <= sclS1_ff;
            sclPrev_ff <= sclS2_ff;
            sdaS1_ff <= sdaIn;
            sdaS2_ff <= sdaS1_ff;
            sdaPrev_ff <= sdaS2_ff;
        end
    end

    wire sclRise = sclS2_ff & ~sclPrev_ff;
    wire sclFall = ~sclS2_ff & sclPrev_ff;
    wire startCond = sclS2_ff & sclPrev_ff & sdaPrev_ff & ~sdaS2_ff;
    wire stopCond = sclS2_ff & sclPrev_ff & ~sdaPrev_ff & sdaS2_ff;
    wire eighthFall = sclFall & (bitCnt_ff == `ICS_BIT_LAST);
    wire ninthFall = sclFall & (bitCnt_ff == `ICS_BIT_ACK);

    // APB access: one wait state, effect at the edge that sees pready
    wire accessCyc = psel & penable & pready_ff;
    wire firstAcc = psel & penable & ~pready_ff;
    wire wrEn = accessCyc & pwrite;
    wire rdEn = accessCyc & ~pwrite;
    wire wrCtrl = wrEn & (paddr == `ICS_OFF_CTRL);
    wire wrData = wrEn & (paddr == `ICS_OFF_DATA);
    wire wrAddr = wrEn & (paddr == `ICS_OFF_ADDR);
    wire wrIrqEn = wrEn & (paddr == `ICS_OFF_IRQ_EN);
    wire wrIrqClr = wrEn & (paddr == `ICS_OFF_IRQ_CLR);
    wire rdData = rdEn & (paddr == `ICS_OFF_DATA);

    always_comb
    begin
        rdVal = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `ICS_OFF_CTRL: rdVal = {29'h0000_0000, clockRelease_ff, ctrl_ff};
            `ICS_OFF_STATUS: rdVal = {24'h00_0000, txWait_ff, addrHold_ff, sclOe_ff, phase_ff, ua_ff, full_ff};
            `ICS_OFF_DATA: rdVal = {24'h00_0000, dataBuf_ff};
            `ICS_OFF_ADDR: rdVal = {22'h00_0000, slaveAddr_ff};
            `ICS_OFF_IRQ_STAT: rdVal = {29'h0000_0000, irqStat_ff};
            `ICS_OFF_IRQ_EN: rdVal = {29'h0000_0000, irqEn_ff};
            `ICS_OFF_IRQ_CLR: rdVal = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= firstAcc;
            pslverr_ff <= firstAcc & ~mapped;
            if (firstAcc & ~pwrite)
                prdata_ff <= rdVal;
        end
    end

    // Software configuration
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_ff <= `ICS_CTRL_RST;
            slaveAddr_ff <= `ICS_ADDR_RST;
            irqEn_ff <= `ICS_IRQ_RST;
        end
        else
        begin
            if (wrCtrl)
            begin
                ctrl_ff.rxStretchEn <= pwdata[`ICS_CTRL_RXEN_BIT];
                ctrl_ff.tenBit <= pwdata[`ICS_CTRL_TENBIT_BIT];
            end
            if (wrAddr)
                slaveAddr_ff <= pwdata[9:0];
            if (wrIrqEn)
                irqEn_ff <= ics_pkg::ics_irq_t'(pwdata[2:0]);
        end
    end

    // Byte decode at the fall after the eighth bit
    wire [7:0] byteIn = rxShift_ff;
    always_comb
    begin
        nxtPhase = ics_pkg::ICS_IDLE;
        nxtHi = hiMatched_ff;
        ackNow = 1'b0;
        uaNow = 1'b0;
        unique case (phase_ff)
            ics_pkg::ICS_ADDR1:
                if (!ctrl_ff.tenBit)
                begin
                    if (byteIn[7:1] == slaveAddr_ff[6:0])
                    begin
                        ackNow = 1'b1;
                        nxtPhase = byteIn[0] ? ics_pkg::ICS_TXDATA : ics_pkg::ICS_RXDATA;
                    end
                end
                else if (byteIn[7:3] == `ICS_TENBIT_PREFIX && byteIn[2:1] == slaveAddr_ff[9:8])
                begin
                    if (!byteIn[0])
                    begin
                        ackNow = 1'b1;
                        uaNow = 1'b1;
                        nxtPhase = ics_pkg::ICS_ADDR2;
                    end
                    else if (hiMatched_ff)
                    begin
                        ackNow = 1'b1;
                        nxtPhase = ics_pkg::ICS_TXDATA;
                    end
                end
            ics_pkg::ICS_ADDR2:
                if (byteIn == slaveAddr_ff[7:0])
                begin
                    ackNow = 1'b1;
                    uaNow = 1'b1;
                    nxtHi = 1'b1;
                    nxtPhase = ics_pkg::ICS_RXDATA;
                end
            ics_pkg::ICS_RXDATA:
            begin
                ackNow = 1'b1;
                nxtPhase = ics_pkg::ICS_RXDATA;
            end
            ics_pkg::ICS_TXDATA: nxtPhase = ics_pkg::ICS_TXDATA;
            default: nxtPhase = ics_pkg::ICS_IDLE;
        endcase
    end

    wire enterTx = ninthFall & (pendPhase_ff == ics_pkg::ICS_TXDATA)
        & ~((phase_ff == ics_pkg::ICS_TXDATA) & masterNack_ff);
    wire rxHit = ninthFall & (phase_ff == ics_pkg::ICS_RXDATA)
        & ctrl_ff.rxStretchEn & full_ff;
    wire txHit = enterTx & ~full_ff;
    wire uaHit = ninthFall & uaPend_ff;
    wire rxLoad = eighthFall & (phase_ff == ics_pkg::ICS_RXDATA) & ~full_ff;
    wire txLoad = (enterTx & full_ff) | (txWait_ff & full_ff & ~wrData);

    // Bit and phase sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bitCnt_ff <= 4'h0;
            rxShift_ff <= 8'h00;
            phase_ff <= ics_pkg::ICS_IDLE;
            pendPhase_ff <= ics_pkg::ICS_IDLE;
            hiMatched_ff <= 1'b0;
            uaPend_ff <= 1'b0;
            masterNack_ff <= 1'b0;
        end
        else if (stopCond)
        begin
            bitCnt_ff <= 4'h0;
            phase_ff <= ics_pkg::ICS_IDLE;
            hiMatched_ff <= 1'b0;
            uaPend_ff <= 1'b0;
        end
        else if (startCond)
        begin
            bitCnt_ff <= 4'h0;
            phase_ff <= ics_pkg::ICS_ADDR1;
            uaPend_ff <= 1'b0;
        end
        else if (sclRise && bitCnt_ff < `ICS_BIT_ACK)
        begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
            if (bitCnt_ff < `ICS_BIT_LAST)
                rxShift_ff <= {rxShift_ff[6:0], sdaS2_ff};
            else
                masterNack_ff <= sdaS2_ff;
        end
        else if (eighthFall)
        begin
            pendPhase_ff <= nxtPhase;
            hiMatched_ff <= nxtHi;
            uaPend_ff <= uaNow;
        end
        else if (ninthFall)
        begin
            bitCnt_ff <= 4'h0;
            uaPend_ff <= 1'b0;
            phase_ff <= ((phase_ff == ics_pkg::ICS_TXDATA) & masterNack_ff) ? ics_pkg::ICS_IDLE : pendPhase_ff;
        end
    end

    // Data buffer and its full flag; hardware set wins over a read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            dataBuf_ff <= 8'h00;
        else if (wrData)
            dataBuf_ff <= pwdata[7:0];
        else if (rxLoad)
            dataBuf_ff <= byteIn;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            full_ff <= 1'b0;
        else if (wrData | rxLoad)
            full_ff <= 1'b1;
        else if (rdData | txLoad)
            full_ff <= 1'b0;
    end

    // Transmit shifter; waits until software loads the buffer, clock held until the release bit is set
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txShift_ff <= 8'h00;
            txWait_ff <= 1'b0;
        end
        else
        begin
            if (txLoad)
                txShift_ff <= dataBuf_ff;
            if (txHit)
                txWait_ff <= 1'b1;
            else if (txLoad | startCond | stopCond)
                txWait_ff <= 1'b0;
        end
    end

    // Release bit: a hardware stretch wins over a same-cycle software write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            clockRelease_ff <= `ICS_RELEASE_RST;
        else if (rxHit | txHit)
            clockRelease_ff <= 1'b0;
        else if (wrCtrl)
            clockRelease_ff <= pwdata[`ICS_CTRL_RELEASE_BIT];
    end

    // Ten-bit address hold, freed by an address register write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addrHold_ff <= 1'b0;
            ua_ff <= 1'b0;
        end
        else if (uaHit)
        begin
            addrHold_ff <= 1'b1;
            ua_ff <= 1'b1;
        end
        else if (wrAddr)
        begin
            addrHold_ff <= 1'b0;
            ua_ff <= 1'b0;
        end
    end

    // Clock pull: only engaged once the line already reads low
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclOe_ff <= 1'b0;
            sclOut_ff <= 1'b0;
        end
        else
        begin
            sclOut_ff <= 1'b0;
            sclOe_ff <= (~clockRelease_ff | addrHold_ff) & (sclOe_ff | ~sclS2_ff);
        end
    end

    // Data pin: acknowledge and transmit bits, changed on clock falls or on a buffer load during a transmit stretch
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sdaOe_ff <= 1'b0;
        else if (startCond | stopCond)
            sdaOe_ff <= 1'b0;
        else if (eighthFall)
            sdaOe_ff <= ackNow & (phase_ff != ics_pkg::ICS_TXDATA);
        else if (ninthFall)
            sdaOe_ff <= enterTx & full_ff & ~dataBuf_ff[7];
        else if (txWait_ff & txLoad)
            sdaOe_ff <= ~dataBuf_ff[7];
        else if (sclFall && phase_ff == ics_pkg::ICS_TXDATA && bitCnt_ff < `ICS_BIT_LAST)
            sdaOe_ff <= ~txShift_ff[3'(4'h7 - bitCnt_ff)];
    end

    // Interrupt status: set wins over clear
    always_comb
    begin
        irqEv.byteDone = ninthFall & (phase_ff != ics_pkg::ICS_IDLE);
        irqEv.stretch = rxHit | txHit | uaHit;
        irqEv.overflow = eighthFall & (phase_ff == ics_pkg::ICS_RXDATA) & full_ff;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irqStat_ff <= `ICS_IRQ_RST;
            irq_ff <= 1'b0;
        end
        else
        begin
            irqStat_ff <= (irqStat_ff & ~(wrIrqClr ? pwdata[2:0] : 3'h0)) | irqEv;
            irq_ff <= |(irqStat_ff & irqEn_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign sclOut = sclOut_ff;
    assign sclOe = sclOe_ff;
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_ff;
    assign irq = irq_ff;

    a_rx_full_stretch: assert property (rxHit |=> !clockRelease_ff ##1 sclOe_ff)
        else $error("receive stretch did not pull clock");
    a_pull_after_low: assert property ($rose(sclOe_ff) |-> !$past(sclS2_ff))
        else $error("clock pulled before it read low");
    a_hold_while_clear: assert property (!clockRelease_ff && sclOe_ff && !wrCtrl |=> sclOe_ff)
        else $error("clock released while release bit clear");
    a_read_clears_full: assert property (rdData && !rxLoad && !wrData |=> !full_ff)
        else $error("buffer read left full flag set");
    a_sw_release_set: assert property (wrCtrl && pwdata[`ICS_CTRL_RELEASE_BIT] && !rxHit && !txHit
        |=> clockRelease_ff)
        else $error("software release write lost");
    a_addr_hold_free: assert property (addrHold_ff && wrAddr && !uaHit |=> !addrHold_ff ##1 !sclOe_ff
        || clockRelease_ff == 1'b0)
        else $error("address write did not free clock");
    a_ua_keeps_release: assert property (uaHit && !rxHit && !txHit && !wrCtrl
        |=> addrHold_ff && ua_ff && clockRelease_ff == $past(clockRelease_ff))
        else $error("address stretch touched release bit");
    a_tx_empty_stretch: assert property (txHit |=> !clockRelease_ff && txWait_ff)
        else $error("transmit stretch missing");
    a_tx_full_no_stretch: assert property (enterTx && full_ff && !wrCtrl && !rxHit
        |=> clockRelease_ff == $past(clockRelease_ff))
        else $error("loaded transmit still stretched");
    a_addr_no_bf: assert property (ninthFall && phase_ff != ics_pkg::ICS_RXDATA && !txHit && !wrCtrl
        |=> clockRelease_ff == $past(clockRelease_ff))
        else $error("buffer stretch in address phase");
    a_open_drain: assert property (sclOe_ff |-> !sclOut_ff)
        else $error("clock driven high");

endmodule
`default_nettype wire

// *** bench/ics_i2c_master.sv ***
`timescale 1ns/10ps
`default_nettype none

module ics_i2c_master (
    // Clock
    input wire logic clk,
    // Resolved bus wires
    input wire logic sclLine,
    input wire logic sdaLine,
    // Open-drain pulls, high pulls low
    output var logic sclPull,
    output var logic sdaPull,
    // Set when a stretch never ended
    output var logic stuck
);
    initial
    begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
        stuck = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Let SCL go and wait while any device still holds it low
    task automatic scl_high(input int hold);
        int k;
        k = 0;
        sclPull <= 1'b0;
        @(posedge clk);
        while (sclLine !== 1'b1 && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 3000)
            stuck <= 1'b1;
        cyc(hold);
    endtask

    task automatic put_bit(input logic b, input int hold, output logic r);
        sdaPull <= ~b;
        cyc(2);
        scl_high(hold);
        r = sdaLine;
        sclPull <= 1'b1;
        cyc(2);
    endtask

    // Also serves as repeated start
    task automatic bus_start();
        sdaPull <= 1'b0;
        cyc(2);
        scl_high(3);
        sdaPull <= 1'b1;
        cyc(4);
        sclPull <= 1'b1;
        cyc(2);
    endtask

    task automatic bus_stop();
        sdaPull <= 1'b1;
        cyc(2);
        scl_high(3);
        sdaPull <= 1'b0;
        cyc(4);
    endtask

    task automatic write_byte(input logic [7:0] d, input int hold, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], 3, r);
        put_bit(1'b1, hold, r);
        ack = ~r;
    endtask

    task automatic read_byte(input logic ackIt, input int hold, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, 3, r);
            d[i] = r;
        end
        put_bit(~ackIt, hold, r);
    endtask
endmodule

`default_nettype wire

// *** bench/tb_i2c_slave_clock_stretch.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ics_cfg.svh"

module tb_i2c_slave_clock_stretch;
    localparam logic [7:0] CT = `ICS_OFF_CTRL;
    localparam logic [7:0] ST = `ICS_OFF_STATUS;
    localparam logic [7:0] DT = `ICS_OFF_DATA;
    localparam logic [7:0] AD = `ICS_OFF_ADDR;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rv;
    logic pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, irq, mScl, mSda, stuck, er, ack;
    wire logic sclLine = ~(sclOe | mScl);
    wire logic sdaLine = ~(sdaOe | mSda);
    int fails = 0;
    int n_compared = 0;
    int seed = 18719;
    logic [7:0] d0, d1, rb;
    logic [9:0] a10;
    logic [6:0] a7;

    always #5 clk = ~clk;

    ics_clock_stretch dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .irq(irq));
    ics_i2c_master mst (.clk(clk), .sclLine(sclLine), .sdaLine(sdaLine), .sclPull(mScl),
        .sdaPull(mSda), .stuck(stuck));

    function automatic logic [31:0] ctl(input logic rel, input logic ten, input logic rx);
        return {29'h0, rel, ten, rx};
    endfunction

    function automatic logic [7:0] hi(input logic [9:0] a, input logic r);
        return {5'h1e, a[9:8], r};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk1(input string nm, input logic s, input logic e);
        chk(nm, {31'h0, s}, {31'h0, e});
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            fails++;
            final_report();
        end
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rv & m, e);
    endtask

    // Give the stretch time to appear after the ninth fall
    task automatic hold(input logic e);
        cyc(6);
        chk1("sclOe", sclOe, e);
    endtask

    initial
    begin
        cyc(60000);
        fails++;
        final_report();
    end

    initial
    begin
        a7 = 7'($random(seed));
        a10 = 10'($random(seed));
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        cyc(10);
        rst_b <= 1'b1;
        cyc(4);
        rd("ctrl", CT, 32'hffff_ffff, ctl(1, 0, 0));
        apb(1'b0, 8'h1c, 32'h0);
        chk1("slverr", er, 1'b1);
        apb(1'b1, AD, {25'h0, a7});
        apb(1'b1, `ICS_OFF_IRQ_EN, 32'h2);
        apb(1'b1, CT, ctl(1, 0, 1));
        mst.bus_start();
        mst.write_byte({a7, 1'b0}, 3, ack);
        chk1("ack", ack, 1'b1);
        mst.write_byte(d0, 3, ack);
        hold(1'b1);
        rd("rel", CT, 32'h4, 32'h0);
        chk1("irq", irq, 1'b1);
        cyc(20);
        chk1("line", sclLine, 1'b0);
        rd("data", DT, 32'hff, {24'h0, d0});
        rd("full", ST, 32'h1, 32'h0);
        apb(1'b1, `ICS_OFF_IRQ_EN, 32'h0);
        cyc(2);
        chk1("irqmask", irq, 1'b0);
        apb(1'b1, `ICS_OFF_IRQ_CLR, 32'h7);
        apb(1'b1, `ICS_OFF_IRQ_EN, 32'h2);
        cyc(2);
        chk1("irqclr", irq, 1'b0);
        apb(1'b1, CT, ctl(1, 0, 1));
        cyc(2);
        chk1("free", sclOe, 1'b0);
        // Slow ninth clock lets software read the byte before the fall
        fork
            mst.write_byte(d1, 60, ack);
            begin
                rv = 32'h0;
                for (int i = 0; i < 30 && rv[0] !== 1'b1; i++)
                    apb(1'b0, ST, 32'h0);
                rd("early", DT, 32'hff, {24'h0, d1});
            end
        join
        hold(1'b0);
        rd("rel", CT, 32'h4, 32'h4);
        apb(1'b1, CT, ctl(1, 0, 0));
        mst.write_byte(d0, 3, ack);
        hold(1'b0);
        mst.bus_stop();
        apb(1'b1, AD, {22'h0, a10});
        apb(1'b1, CT, ctl(1, 1, 1));
        mst.bus_start();
        mst.write_byte(hi(a10, 1'b0), 3, ack);
        hold(1'b1);
        rd("upd", ST, 32'h3, 32'h3);
        rd("rel", CT, 32'h4, 32'h4);
        apb(1'b1, AD, {22'h0, a10});
        cyc(2);
        chk1("free", sclOe, 1'b0);
        mst.write_byte(a10[7:0], 3, ack);
        hold(1'b1);
        rd("upd", ST, 32'h2, 32'h2);
        rd("data", DT, 32'hff, {24'h0, d0});
        apb(1'b1, AD, {22'h0, a10});
        cyc(2);
        chk1("free", sclOe, 1'b0);
        mst.write_byte(d1, 3, ack);
        hold(1'b1);
        rd("rel", CT, 32'h4, 32'h0);
        rd("data", DT, 32'hff, {24'h0, d1});
        apb(1'b1, CT, ctl(1, 1, 1));
        mst.bus_start();
        mst.write_byte(hi(a10, 1'b1), 3, ack);
        hold(1'b1);
        rd("upd", ST, 32'h3, 32'h0);
        apb(1'b1, DT, {24'h0, d0});
        apb(1'b1, CT, ctl(1, 1, 1));
        mst.read_byte(1'b0, 3, rb);
        chk("tx", {24'h0, rb}, {24'h0, d0});
        mst.bus_stop();
        apb(1'b1, AD, {25'h0, a7});
        apb(1'b1, CT, ctl(1, 0, 0));
        mst.bus_start();
        mst.write_byte({a7, 1'b1}, 3, ack);
        hold(1'b1);
        rd("rel", CT, 32'h4, 32'h0);
        apb(1'b1, DT, {24'h0, d1});
        apb(1'b1, CT, ctl(1, 0, 0));
        fork
            mst.read_byte(1'b1, 60, rb);
            begin
                cyc(70);
                apb(1'b1, DT, {24'h0, d0});
            end
        join
        chk("tx", {24'h0, rb}, {24'h0, d1});
        hold(1'b0);
        mst.read_byte(1'b0, 3, rb);
        chk("tx", {24'h0, rb}, {24'h0, d0});
        mst.bus_stop();
        chk1("stuck", stuck, 1'b0);
        chk1("sclOut", sclOut, 1'b0);
        final_report();
    end
endmodule

`default_nettype wire
